// File: logic/hpl_cfg.svh
/*
 * Constants of the hub loader and power block: register offsets, field
 * positions, default identifiers and serial memory timing counts.
 * Assumes a 100 MHz core clock and a serial memory in 16-bit organisation.
 */
`ifndef HPL_CFG_SVH
`define HPL_CFG_SVH

// core clock and serial memory clock timing
`define HPL_CLK_NS 10
`define HPL_SK_HALF_NS 500
`define HPL_SK_HALF_CYC ((`HPL_SK_HALF_NS + `HPL_CLK_NS - 1) / `HPL_CLK_NS)
`define HPL_SETTLE_CYC 4

// read command: start bit, read opcode, word address zero
`define HPL_CMD 8'hC0
`define HPL_CMD_BITS 8
// dummy bit plus three 16-bit words
`define HPL_RX_BITS 49
`define HPL_LAST_BIT (`HPL_CMD_BITS + `HPL_RX_BITS - 1)
`define HPL_GANG_BIT 14

// identifiers used when no memory is fitted; values are arbitrary
`define HPL_DEF_VID 16'h1234
`define HPL_DEF_PID 16'h5678

// register byte offsets
`define HPL_REG_CTRL 8'h00
`define HPL_REG_STATUS 8'h04
`define HPL_REG_IDS 8'h08
`define HPL_REG_IRQ_STAT 8'h0C
`define HPL_REG_IRQ_MASK 8'h10

// status register fields
`define HPL_ST_DONE 0
`define HPL_ST_BUSY 1
`define HPL_ST_GANG 2
`define HPL_ST_BUS_POWER_STRAP 3
`define HPL_ST_FASTCLK 4
`define HPL_ST_EXTERNAL_MEMORY_STRAP 5
`define HPL_ST_FAULT 8

// interrupt fields: bits 3..0 overcurrent per port, bit 4 load done
`define HPL_IRQ_LOAD 4
`define HPL_IRQ_W 5

`define HPL_RESP_OKAY 2'h0
`define HPL_RESP_SLVERR 2'h2

`endif

// File: logic/hpl_pkg.sv
/*
 * Types of the hub loader and power block: loader states, strap bundle
 * and the state record of the top module, all but its two clock select flip-flops.
 * Assumes hpl_cfg.svh is on the include path.
 */
`default_nettype none
`include "hpl_cfg.svh"

package hpl_pkg;

    typedef enum logic [1:0] {
        HPL_SETTLE,
        HPL_XFER,
        HPL_DONE
    } hpl_phase_t;

    // strap pins, in synchroniser order
    typedef struct packed {
        logic bus_pwr;
        logic clk_src;
        logic xtal_in;
        logic ext_mem;
    } hpl_straps_t;

    typedef struct packed {
        hpl_straps_t strap_s1;
        hpl_straps_t strap_s2;
        hpl_straps_t strap;
        logic [3:0] oc_s1;
        logic [3:0] oc_s2;
        logic [3:0] oc_prev;
        logic dat_s1;
        logic dat_s2;
        hpl_phase_t phase;
        logic [5:0] half;
        logic [5:0] bit_idx;
        logic [47:0] shift;
        logic sk;
        logic sk_oe;
        logic dat_out;
        logic dat_oe;
        logic pd_en;
        logic cfg_valid;
        logic gang_rom;
        logic [15:0] vendor_identifier;
        logic [15:0] product_identifier;
        logic [3:0] ctrl_pwr;
        logic [3:0] off;
        logic [3:0] pwr;
        logic [`HPL_IRQ_W-1:0] ists;
        logic [`HPL_IRQ_W-1:0] imask;
        logic irq;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } hpl_state_t;

endpackage : hpl_pkg

`default_nettype wire

// File: logic/hpl_loader.sv
/*
 * Configuration loader and port power control of a four port hub.
 * Reads identifiers and the gang setting from a three-wire serial memory
 * once after reset, then releases the pins; drives port power from the
 * overcurrent inputs; reports clock and power modes; AXI4-Lite registers.
 * Assumes strap and sense pins are asynchronous and the memory chip select
 * follows system power-on reset outside this block.
 */
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - ganged: ports switch together, any fault kills all
// - individual: fault removes only that port's power
// - bus-power strap and gang select give four modes
// - both clock straps low: run from 6-MHz crystal
// - strap and crystal input high: 48-MHz clock input
// - memory strap high: default ids, shared pin gangs
// - memory strap low: shared pins are memory lines
// - pulldowns on only while memory interface enabled
// - word0 bit 14 gang, word1 vendor, word2 product
// - one read after reset, never again
// - send start one, read opcode, address zero
// - release data line after address, memory drives
// - block drives clock; memory changes on rising edge
// - after third word, memory pins go high impedance
module hpl_loader
    import hpl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] overcurrent_sense_n_i,
    input wire logic bus_power_strap_i,
    input wire logic clock_source_strap_i,
    input wire logic crystal_in_i,
    input wire logic external_memory_strap_i,
    input wire logic memory_data_or_gang_select_i,
    output logic serial_memory_data_o,
    output logic serial_memory_data_oe_o,
    output logic serial_memory_clock_o,
    output logic serial_memory_clock_oe_o,
    output logic memory_pulldown_en_o,
    output logic [3:0] port_power_enable_o,
    output logic oscillator_enable_o,
    output logic fast_clock_select_o,
    output logic irq_o
);

    localparam logic [5:0] HALF_LAST = 6'(`HPL_SK_HALF_CYC - 1);
    localparam logic [5:0] LAST_BIT = 6'(`HPL_LAST_BIT);
    localparam logic [5:0] CMD_BITS = 6'(`HPL_CMD_BITS);
    localparam logic [5:0] SETTLE_LAST = 6'(`HPL_SETTLE_CYC - 1);
    localparam logic [7:0] CMD = `HPL_CMD;

    hpl_state_t s_reg;
    hpl_state_t s_next;

    logic [3:0] fault;
    logic [3:0] trip;
    logic [3:0] req;
    logic [3:0] oc_evt;
    logic ganged;
    logic fast_mode;
    logic [31:0] bmask;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_ok;
    logic load_evt;
    logic [`HPL_IRQ_W-1:0] iclr;

    // next state of the whole block but the two clock select flip-flops
    always_comb begin
        s_next = s_reg;
        load_evt = 1'b0;
        iclr = '0;
        wr_ok = 1'b0;

        // every strap, sense and memory data pin passes two flip-flops first
        s_next.strap_s1 = '{bus_pwr: bus_power_strap_i, clk_src: clock_source_strap_i,
                            xtal_in: crystal_in_i, ext_mem: external_memory_strap_i};
        s_next.strap_s2 = s_reg.strap_s1;
        s_next.oc_s1 = overcurrent_sense_n_i;
        s_next.oc_s2 = s_reg.oc_s1;
        s_next.oc_prev = s_reg.oc_s2;
        s_next.dat_s1 = memory_data_or_gang_select_i;
        s_next.dat_s2 = s_reg.dat_s1;

        // loader sequence
        unique case (s_reg.phase)
            HPL_SETTLE: begin
                s_next.half = s_reg.half + 6'h01;
                if (s_reg.half == SETTLE_LAST) begin
                    // straps caught once, after the synchronisers filled
                    s_next.strap = s_reg.strap_s2;
                    s_next.half = '0;
                    s_next.bit_idx = '0;
                    if (s_reg.strap_s2.ext_mem) begin
                        s_next.phase = HPL_DONE;
                        s_next.vendor_identifier = `HPL_DEF_VID;
                        s_next.product_identifier = `HPL_DEF_PID;
                        s_next.cfg_valid = 1'b1;
                        s_next.pd_en = 1'b0;
                        load_evt = 1'b1;
                    end else begin
                        s_next.phase = HPL_XFER;
                        s_next.pd_en = 1'b1;
                        s_next.sk_oe = 1'b1;
                        s_next.dat_oe = 1'b1;
                        s_next.dat_out = CMD[7];
                    end
                end
            end
            HPL_XFER: begin
                s_next.half = s_reg.half + 6'h01;
                if (s_reg.half == HALF_LAST) begin
                    s_next.half = '0;
                    s_next.sk = ~s_reg.sk;
                    if (s_reg.sk) begin
                        // falling edge: memory data settled half a period ago
                        if (s_reg.bit_idx >= CMD_BITS) begin
                            s_next.shift = {s_reg.shift[46:0], s_reg.dat_s2};
                        end
                        s_next.bit_idx = s_reg.bit_idx + 6'h01;
                        if (s_reg.bit_idx + 6'h01 < CMD_BITS) begin
                            s_next.dat_out = CMD[3'(3'h7 - s_reg.bit_idx[2:0] - 3'h1)];
                        end else begin
                            s_next.dat_oe = 1'b0;
                            s_next.dat_out = 1'b0;
                        end
                        if (s_reg.bit_idx == LAST_BIT) begin
                            // the dummy bit has dropped out of the top
                            s_next.phase = HPL_DONE;
                            s_next.sk_oe = 1'b0;
                            s_next.sk = 1'b0;
                            s_next.gang_rom = s_next.shift[32 + `HPL_GANG_BIT];
                            s_next.vendor_identifier = s_next.shift[31:16];
                            s_next.product_identifier = s_next.shift[15:0];
                            s_next.cfg_valid = 1'b1;
                            load_evt = 1'b1;
                        end
                    end
                end
            end
            HPL_DONE: begin
                // terminal: pins stay released, pulldowns only hold them
                s_next.sk_oe = 1'b0;
                s_next.dat_oe = 1'b0;
            end
        endcase

        // mode decode from caught straps; the gang select pin is read live
        fault = ~s_reg.oc_s2;
        oc_evt = s_reg.oc_prev & ~s_reg.oc_s2;
        ganged = s_reg.strap.ext_mem ? s_reg.dat_s2 : s_reg.gang_rom;
        fast_mode = s_reg.strap.clk_src & s_reg.strap.xtal_in;

        // port power; a tripped port stays off until software drops its request
        for (int i = 0; i < 4; i++) begin
            req[i] = ganged ? s_reg.ctrl_pwr[0] : s_reg.ctrl_pwr[i];
            trip[i] = ganged ? |fault : fault[i];
            s_next.off[i] = (s_reg.off[i] | trip[i]) & req[i];
            s_next.pwr[i] = s_reg.cfg_valid & req[i] & ~trip[i] & ~s_reg.off[i];
        end

        // write: address and data taken in either order
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        bmask = {{8{s_reg.wstrb[3]}}, {8{s_reg.wstrb[2]}},
                 {8{s_reg.wstrb[1]}}, {8{s_reg.wstrb[0]}}};
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            wr_ok = 1'b1;
            unique case (s_reg.aw_addr)
                `HPL_REG_CTRL: begin
                    s_next.ctrl_pwr = (s_reg.ctrl_pwr & ~bmask[3:0])
                        | (s_reg.wdata[3:0] & bmask[3:0]);
                end
                `HPL_REG_IRQ_STAT: iclr = s_reg.wdata[`HPL_IRQ_W-1:0] & bmask[`HPL_IRQ_W-1:0];
                `HPL_REG_IRQ_MASK: begin
                    s_next.imask = (s_reg.imask & ~bmask[`HPL_IRQ_W-1:0])
                        | (s_reg.wdata[`HPL_IRQ_W-1:0] & bmask[`HPL_IRQ_W-1:0]);
                end
                `HPL_REG_STATUS, `HPL_REG_IDS: wr_ok = 1'b1; // read-only, write ignored
                default: wr_ok = 1'b0;
            endcase
            s_next.bresp = wr_ok ? `HPL_RESP_OKAY : `HPL_RESP_SLVERR;
        end else if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
        s_next.wready = ~s_next.w_got & ~s_next.bvalid;

        // read
        status_word = '0;
        status_word[`HPL_ST_DONE] = s_reg.cfg_valid;
        status_word[`HPL_ST_BUSY] = (s_reg.phase == HPL_XFER);
        status_word[`HPL_ST_GANG] = ganged;
        status_word[`HPL_ST_BUS_POWER_STRAP] = s_reg.strap.bus_pwr;
        status_word[`HPL_ST_FASTCLK] = fast_mode;
        status_word[`HPL_ST_EXTERNAL_MEMORY_STRAP] = s_reg.strap.ext_mem;
        status_word[`HPL_ST_FAULT +: 4] = fault;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            `HPL_REG_CTRL: rd_word = {28'h0000000, s_reg.ctrl_pwr};
            `HPL_REG_STATUS: rd_word = status_word;
            `HPL_REG_IDS: rd_word = {s_reg.vendor_identifier, s_reg.product_identifier};
            `HPL_REG_IRQ_STAT: rd_word = {27'h0000000, s_reg.ists};
            `HPL_REG_IRQ_MASK: rd_word = {27'h0000000, s_reg.imask};
            default: begin
                rd_word = '0;
                rd_ok = 1'b0;
            end
        endcase
        if (s_axi_arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_word;
            s_next.rresp = rd_ok ? `HPL_RESP_OKAY : `HPL_RESP_SLVERR;
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        s_next.arready = ~s_next.rvalid;

        // sticky events: a new event wins over a clear in the same cycle
        s_next.ists = (s_reg.ists & ~iclr) | {load_evt, oc_evt};
        s_next.irq = |(s_next.ists & s_next.imask);
    end

    // single state register, synchronous reset
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output straight from a flip-flop
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign serial_memory_data_o = s_reg.dat_out;
    assign serial_memory_data_oe_o = s_reg.dat_oe;
    assign serial_memory_clock_o = s_reg.sk;
    assign serial_memory_clock_oe_o = s_reg.sk_oe;
    assign memory_pulldown_en_o = s_reg.pd_en;
    assign port_power_enable_o = s_reg.pwr;
    assign irq_o = s_reg.irq;

    // clock source selection; crystal amplifier runs unless the fast input is used
    logic osc_en_reg;
    logic fast_sel_reg;
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            osc_en_reg <= 1'b1;
            fast_sel_reg <= 1'b0;
        end else begin
            osc_en_reg <= ~fast_mode;
            fast_sel_reg <= fast_mode;
        end
    end
    assign oscillator_enable_o = osc_en_reg;
    assign fast_clock_select_o = fast_sel_reg;

endmodule : hpl_loader

`default_nettype wire

// File: bench/hpl_loader_checker.sv
/* pin-level checks of the loader and port power block.
   assumes it is bound onto hpl_loader and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module hpl_loader_checker (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] overcurrent_sense_n_i,
    input wire logic clock_source_strap_i,
    input wire logic crystal_in_i,
    input wire logic external_memory_strap_i,
    input wire logic memory_data_or_gang_select_i,
    input wire logic serial_memory_data_o,
    input wire logic serial_memory_data_oe_o,
    input wire logic serial_memory_clock_o,
    input wire logic serial_memory_clock_oe_o,
    input wire logic memory_pulldown_en_o,
    input wire logic [3:0] port_power_enable_o,
    input wire logic oscillator_enable_o,
    input wire logic fast_clock_select_o
);
    logic [6:0] sk_cnt_reg;
    logic [6:0] half_reg;
    logic [15:0] oc_hist_reg;
    logic [3:0] fault_old;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // rising clock count, half-period length and a short sense history
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sk_cnt_reg <= 7'h00;
            half_reg <= 7'h00;
            oc_hist_reg <= 16'hFFFF;
        end else begin
            if ($rose(serial_memory_clock_o)) sk_cnt_reg <= sk_cnt_reg + 7'h01;
            if ($changed(serial_memory_clock_o)) half_reg <= 7'h00;
            else if (half_reg != 7'h7F) half_reg <= half_reg + 7'h01;
            oc_hist_reg <= {oc_hist_reg[11:0], overcurrent_sense_n_i};
        end
    end
    // a port low for five samples has certainly passed the synchroniser
    assign fault_old = ~(overcurrent_sense_n_i | oc_hist_reg[3:0] | oc_hist_reg[7:4]
        | oc_hist_reg[11:8] | oc_hist_reg[15:12]);
    property p_cmd_bits;
        $rose(serial_memory_clock_o) && serial_memory_data_oe_o |->
            serial_memory_data_o == (sk_cnt_reg < 7'h02);
    endproperty
    a_cmd_bits: assert property (p_cmd_bits) else $error("command bit wrong");
    property p_one_read;
        sk_cnt_reg <= 7'h39;
    endproperty
    a_one_read: assert property (p_one_read) else $error("extra memory clock");
    property p_release;
        $fell(serial_memory_data_oe_o) |-> sk_cnt_reg == 7'h08 && !serial_memory_clock_o;
    endproperty
    a_release: assert property (p_release) else $error("data release wrong");
    property p_half;
        $changed(serial_memory_clock_o) && sk_cnt_reg != 7'h00 |-> half_reg inside {[7'h30:7'h32]};
    endproperty
    a_half: assert property (p_half) else $error("clock half period wrong");
    property p_idle;
        sk_cnt_reg == 7'h39 && !serial_memory_clock_o |->
            ##[0:8] (!serial_memory_clock_oe_o && !serial_memory_data_oe_o);
    endproperty
    a_idle: assert property (p_idle) else $error("pins not released");
    property p_pulldown;
        serial_memory_clock_oe_o |-> memory_pulldown_en_o && !external_memory_strap_i;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pulldown wrong");
    property p_nomem;
        external_memory_strap_i [*8] |-> !memory_pulldown_en_o && !serial_memory_clock_oe_o;
    endproperty
    a_nomem: assert property (p_nomem) else $error("memory pins active");
    property p_gang;
        (external_memory_strap_i && memory_data_or_gang_select_i
            && overcurrent_sense_n_i != 4'hF) [*6] |-> port_power_enable_o == 4'h0;
    endproperty
    a_gang: assert property (p_gang) else $error("ganged port left on");
    property p_port_fault;
        (fault_old & port_power_enable_o) == 4'h0;
    endproperty
    a_port_fault: assert property (p_port_fault) else $error("faulty port on");
    property p_fast;
        (clock_source_strap_i && crystal_in_i) [*7] |-> fast_clock_select_o && !oscillator_enable_o;
    endproperty
    a_fast: assert property (p_fast) else $error("fast clock mode wrong");
    property p_xtal;
        (!clock_source_strap_i && !crystal_in_i) [*6] |-> !fast_clock_select_o && oscillator_enable_o;
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal mode wrong");
    c_load: cover property (sk_cnt_reg == 7'h39);
    c_one_off: cover property (port_power_enable_o == 4'hE);
    c_fast: cover property (fast_clock_select_o);
endmodule : hpl_loader_checker
bind hpl_loader hpl_loader_checker hpl_loader_checker_inst (.ref_clk_i, .resetn_i,
    .overcurrent_sense_n_i, .clock_source_strap_i, .crystal_in_i, .external_memory_strap_i,
    .memory_data_or_gang_select_i, .serial_memory_data_o, .serial_memory_data_oe_o,
    .serial_memory_clock_o, .serial_memory_clock_oe_o, .memory_pulldown_en_o,
    .port_power_enable_o, .oscillator_enable_o, .fast_clock_select_o);
`default_nettype wire

// File: bench/hpl_mem_model.sv
/* serial memory model: answers one read of three words on the shared line.
   assumes the bench resolves the shared line and its pulldown. */
`timescale 1ns/100ps
`default_nettype none
module hpl_mem_model (
    input wire logic cs_i,
    input wire logic sk_i,
    input wire logic din_i,
    input wire logic [47:0] image_i,
    output logic dout_o,
    output logic doe_o,
    output logic [7:0] cmd_o,
    output int edges_o
);
    // counters start clean even if the first select edge is missed at time zero
    initial begin
        doe_o = 1'b0;
        edges_o = 0;
        cmd_o = 8'h00;
    end
    // data only ever changes on the rising clock
    always @(posedge sk_i or negedge cs_i) begin
        if (!cs_i) begin
            edges_o <= 0;
            cmd_o <= 8'h00;
            doe_o <= 1'b0;
        end else begin
            edges_o <= edges_o + 1;
            if (edges_o < 8) cmd_o <= {cmd_o[6:0], din_i};
            // dummy zero, then words back to back as the address self-advances
            else if (edges_o < 57 && cmd_o == 8'hC0) begin
                doe_o <= 1'b1;
                dout_o <= (edges_o == 8) ? 1'b0 : image_i[56 - edges_o];
            end
        end
    end
    // let go once the last bit is taken, so a late sample sees the pulldown
    always @(negedge sk_i) if (edges_o == 57) doe_o <= 1'b0;
endmodule : hpl_mem_model
`default_nettype wire

// File: bench/test_hub_eeprom_loader_power_control.sv
/* bench of the hub loader: register master, memory model, straps and sense pins.
   assumes the design, checker and memory model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "hpl_cfg.svh"
module test_hub_eeprom_loader_power_control;
    logic ref_clk = 1'b0, resetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] oc_n = 4'hF, pwr;
    logic bus_strap = 1'b0, clk_strap = 1'b0, xtal = 1'b0, ext = 1'b0, gang_drv = 1'b0;
    logic sd_o, sd_oe, sk, sk_oe, pd_en, osc_en, fast, irq, m_d, m_oe;
    logic [7:0] cmd;
    logic [47:0] image = 48'h0;
    int edges;
    int n_mismatch = 0, n_tests = 0;
    // shared data line: block, then memory, then pulldown or the gang strap
    wire logic pin = sd_oe ? sd_o : (m_oe ? m_d : (pd_en ? 1'b0 : gang_drv));
    always #5 ref_clk = ~ref_clk;
    hpl_loader hpl_loader_inst (.ref_clk_i(ref_clk), .resetn_i(resetn), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .overcurrent_sense_n_i(oc_n), .bus_power_strap_i(bus_strap),
        .clock_source_strap_i(clk_strap), .crystal_in_i(xtal), .external_memory_strap_i(ext),
        .memory_data_or_gang_select_i(pin), .serial_memory_data_o(sd_o),
        .serial_memory_data_oe_o(sd_oe), .serial_memory_clock_o(sk),
        .serial_memory_clock_oe_o(sk_oe), .memory_pulldown_en_o(pd_en),
        .port_power_enable_o(pwr), .oscillator_enable_o(osc_en), .fast_clock_select_o(fast),
        .irq_o(irq));
    // memory select follows reset and exists only when the strap fits it
    hpl_mem_model hpl_mem_model_inst (.cs_i(resetn & ~ext), .sk_i(sk), .din_i(pin),
        .image_i(image), .dout_o(m_d), .doe_o(m_oe), .cmd_o(cmd), .edges_o(edges));
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // bounded wait: always lets one edge pass before looking
    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (s !== 1'b1 && n < lim);
        if (s !== 1'b1) begin
            n_mismatch++;
            $display("mismatch timeout");
            end_sim();
        end
    endtask : wait_hi
    task automatic delay(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : delay
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid & ~s_axi_awready) | (s_axi_wvalid & ~s_axi_wready));
        wait_hi(s_axi_bvalid, 50);
        s_axi_bready <= 1'b0;
        chk("write response", s_axi_bresp, `HPL_RESP_OKAY);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, exp, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        wait_hi(s_axi_arready, 50);
        s_axi_arvalid <= 1'b0;
        wait_hi(s_axi_rvalid, 50);
        s_axi_rready <= 1'b0;
        chk("read data", s_axi_rdata & m, exp);
        chk("read response", s_axi_rresp, er);
    endtask : axi_rd
    // straps settle during reset; they are caught only after release
    task automatic rst(input logic e, input logic [47:0] img);
        resetn <= 1'b0;
        ext <= e;
        image <= img;
        oc_n <= 4'hF;
        delay(4);
        resetn <= 1'b1;
        delay(2);
    endtask : rst
    task automatic load(input logic [47:0] img);
        rst(1'b0, img);
        axi_wr(`HPL_REG_IRQ_MASK, 32'h10);
        wait_hi(irq, 8000);
        chk("command", cmd, 8'hC0);
        chk("clock edges", edges, 57);
        chk("pins released", {sk_oe, sd_oe, pd_en}, 3'b001);
        axi_wr(`HPL_REG_IRQ_STAT, 32'h10);
        chk("irq cleared", irq, 1'b0);
    endtask : load
    task automatic t_rom_gang;
        load({16'h4000, 16'hABCD, 16'h0123});
        axi_rd(`HPL_REG_IDS, 32'hFFFFFFFF, 32'hABCD0123, `HPL_RESP_OKAY);
        axi_rd(`HPL_REG_STATUS, 32'hFFFFFFFF, 32'h00000005, `HPL_RESP_OKAY);
        chk("crystal mode", {osc_en, fast}, 2'b10);
        axi_wr(`HPL_REG_CTRL, 32'h1);
        delay(8);
        chk("ganged on", pwr, 4'hF);
        oc_n <= 4'hB;
        delay(8);
        chk("ganged off", pwr, 4'h0);
        axi_rd(`HPL_REG_IRQ_STAT, 32'hFFFFFFFF, 32'h4, `HPL_RESP_OKAY);
        chk("irq masked", irq, 1'b0);
        axi_wr(`HPL_REG_IRQ_MASK, 32'h4);
        chk("irq raised", irq, 1'b1);
        axi_wr(`HPL_REG_IRQ_STAT, 32'h4);
        chk("irq cleared", irq, 1'b0);
        chk("no second read", edges, 57);
        $display("test rom_gang done");
    endtask : t_rom_gang
    task automatic t_indiv;
        load({16'h0000, 16'h5A5A, 16'hA5A5});
        axi_rd(`HPL_REG_IDS, 32'hFFFFFFFF, 32'h5A5AA5A5, `HPL_RESP_OKAY);
        axi_wr(`HPL_REG_CTRL, 32'hF);
        delay(8);
        chk("ports on", pwr, 4'hF);
        oc_n <= 4'hD;
        delay(8);
        chk("one port off", pwr, 4'hD);
        axi_rd(`HPL_REG_STATUS, 32'hFFFFFFFF, 32'h00000201, `HPL_RESP_OKAY);
        $display("test indiv done");
    endtask : t_indiv
    task automatic t_nomem;
        bus_strap <= 1'b1;
        clk_strap <= 1'b1;
        xtal <= 1'b1;
        gang_drv <= 1'b0;
        rst(1'b1, 48'h0);
        delay(8);
        axi_rd(`HPL_REG_IDS, 32'hFFFFFFFF, {`HPL_DEF_VID, `HPL_DEF_PID}, `HPL_RESP_OKAY);
        chk("memory pins idle", {pd_en, sk_oe, sd_oe}, 3'b000);
        chk("fast clock mode", {osc_en, fast}, 2'b01);
        axi_rd(`HPL_REG_STATUS, 32'h3C, 32'h38, `HPL_RESP_OKAY);
        axi_rd(8'h20, 32'hFFFFFFFF, 32'h0, `HPL_RESP_SLVERR);
        axi_wr(`HPL_REG_CTRL, 32'hF);
        delay(8);
        chk("ports on", pwr, 4'hF);
        oc_n <= 4'hE;
        delay(8);
        chk("one port off", pwr, 4'hE);
        gang_drv <= 1'b1;
        delay(8);
        chk("live gang off", pwr, 4'h0);
        chk("no memory access", edges, 0);
        $display("test nomem done");
    endtask : t_nomem
    initial begin
        @(posedge ref_clk);
        t_rom_gang();
        t_indiv();
        t_nomem();
        end_sim();
    end
endmodule : test_hub_eeprom_loader_power_control
`default_nettype wire
